// ---- verilog/spr_pkg.sv ----
// Constants and field layout of the synthesizer program register bank
package spr_pkg;
  localparam int SPR_WORD_W = 32;
  localparam int SPR_SEL_W = 3;
  localparam int SPR_NUM_REGS = 8;
  // Select codes
  localparam logic [2:0] SPR_SEL_MAIN = 3'h0;
  localparam logic [2:0] SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW = 3'h1;
  localparam logic [2:0] SPR_SEL_REF_DIV = 3'h2;
  localparam logic [2:0] SPR_SEL_FUNCTION = 3'h3;
  localparam logic [2:0] SPR_SEL_CLOCK = 3'h4;
  localparam logic [2:0] SPR_SEL_DEVIATION = 3'h5;
  localparam logic [2:0] SPR_SEL_STEP = 3'h6;
  localparam logic [2:0] SPR_SEL_DELAY = 3'h7;
  // Main register fields
  localparam int SPR_RAMP_BIT = 31;
  localparam int SPR_MUX_HI = 30;
  localparam int SPR_MUX_LO = 27;
  localparam int SPR_INT_HI = 26;
  localparam int SPR_INT_LO = 15;
  localparam int SPR_FHI_HI = 14;
  localparam int SPR_FHI_LO = 3;
  // Second register fields
  localparam int SPR_PHASE_EN_BIT = 28;
  localparam int SPR_FLO_HI = 27;
  localparam int SPR_FLO_LO = 15;
  localparam int SPR_PHASE_HI = 14;
  localparam int SPR_PHASE_LO = 3;
  localparam int SPR_FRACTIONAL_DIVIDE_WORD_SHIFT = 13;
  localparam int SPR_FRACTIONAL_DIVIDE_WORD_W = 25;
  // Third register fields
  localparam int SPR_CSR_BIT = 28;
  localparam int SPR_CP_HI = 27;
  localparam int SPR_CP_LO = 24;
  localparam int SPR_RDIV2_BIT = 21;
  localparam int SPR_DBL_BIT = 20;
  localparam int SPR_RCNT_HI = 19;
  localparam int SPR_RCNT_LO = 15;
  localparam int SPR_CLK1_HI = 14;
  localparam int SPR_CLK1_LO = 3;
  // Function register fields
  localparam int SPR_PD_SENSE_BIT = 6;
  localparam int SPR_PWRDN_BIT = 5;
  localparam logic [31:0] SPR_RESET_WORD = 32'h0000_0000;
endpackage

// ---- verilog/spr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module spr_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // First stage only feeds the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // spr_sync

// ---- verilog/spr_bank.sv ----
// Serial-loaded program register bank with double-buffered settings
`timescale 1ns/1ns
module spr_bank
  import spr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clk,
  input wire logic shift_data,
  input wire logic latch_strobe,
  output logic ramp_enable,
  output logic [3:0] test_signal_output_select,
  output logic [11:0] integer_divide,
  output logic [24:0] fractional_divide_word,
  output logic phase_shift_enable,
  output logic [11:0] phase_word,
  output logic phase_update,
  output logic cycle_slip_reduce_enable,
  output logic [3:0] pump_current,
  output logic ref_half,
  output logic ref_double,
  output logic [4:0] ref_count,
  output logic [11:0] clk1_divide,
  output logic phase_detector_sense,
  output logic power_down,
  output logic [31:0] function_config,
  output logic [31:0] ramp_clock_config,
  output logic [31:0] frequency_deviation_config,
  output logic [31:0] ramp_step_count,
  output logic [31:0] ramp_delay_config
);
  logic [2:0] pins;
  logic sclk_s, sdat_s, latch_s;
  logic sclk_d, latch_d;
  logic sclk_rise, latch_rise;
  logic [31:0] shifter;
  logic [31:0] divider_main_word;
  logic [31:0] fraction_low_phase_word;
  logic [31:0] reference_divider_config;
  logic [31:0] active_low_phase;
  logic [31:0] active_ref_div;
  logic [2:0] sel;
  logic main_write;

  // Pins come from the host's domain, so resynchronise all three
  // Clock and data share one synchroniser so they stay aligned; the price
  // is a two-cycle lag, so each pin level must stand for at least 2 clk
  spr_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({shift_clk, shift_data, latch_strobe}),
    .q(pins)
  );
  assign sclk_s = pins[2];
  assign sdat_s = pins[1];
  assign latch_s = pins[0];

  // Edge history of synchronised levels
  // Reset values match the idle-low pins, so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
      latch_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      latch_d <= latch_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d;
  assign latch_rise = latch_s & ~latch_d;

  // Shift register, MSB first; stays live during power-down
  // Extra bits beyond one word fall out the top; only the last word counts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shifter <= SPR_RESET_WORD;
    end else if (sclk_rise) begin
      shifter <= {shifter[SPR_WORD_W-2:0], sdat_s};
    end
  end

  assign sel = shifter[SPR_SEL_W-1:0];
  assign main_write = latch_rise && (sel == SPR_SEL_MAIN);

  // Latch decode: one register per select code
  // Reserved bits are kept as written; keeping them zero is up to the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divider_main_word <= SPR_RESET_WORD;
      fraction_low_phase_word <= SPR_RESET_WORD;
      reference_divider_config <= SPR_RESET_WORD;
      function_config <= SPR_RESET_WORD;
      ramp_clock_config <= SPR_RESET_WORD;
      frequency_deviation_config <= SPR_RESET_WORD;
      ramp_step_count <= SPR_RESET_WORD;
      ramp_delay_config <= SPR_RESET_WORD;
    end else if (latch_rise) begin
      case (sel)
        SPR_SEL_MAIN: divider_main_word <= shifter;
        SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW: fraction_low_phase_word <= shifter;
        SPR_SEL_REF_DIV: reference_divider_config <= shifter;
        SPR_SEL_FUNCTION: function_config <= shifter;
        SPR_SEL_CLOCK: ramp_clock_config <= shifter;
        SPR_SEL_DEVIATION: frequency_deviation_config <= shifter;
        SPR_SEL_STEP: ramp_step_count <= shifter;
        SPR_SEL_DELAY: ramp_delay_config <= shifter;
        default: ;
      endcase
    end
  end

  // Shadow copies go live only on a main write, so fractional_divide_word halves change together
  // The third register is buffered too, except the slip bit which acts at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_low_phase <= SPR_RESET_WORD;
      active_ref_div <= SPR_RESET_WORD;
    end else if (main_write) begin
      active_low_phase <= fraction_low_phase_word;
      active_ref_div <= reference_divider_config;
    end
  end

  // One-cycle marker that a phase step is due, raised with the live copy
  // A main write with adjustment off leaves the marker low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_update <= 1'b0;
    end else begin
      phase_update <= main_write && fraction_low_phase_word[SPR_PHASE_EN_BIT];
    end
  end

  // Decoded outputs; the bank itself never reacts to power-down
  assign ramp_enable = divider_main_word[SPR_RAMP_BIT];
  assign test_signal_output_select = divider_main_word[SPR_MUX_HI:SPR_MUX_LO];
  assign integer_divide = divider_main_word[SPR_INT_HI:SPR_INT_LO];
  assign fractional_divide_word =
    {divider_main_word[SPR_FHI_HI:SPR_FHI_LO], active_low_phase[SPR_FLO_HI:SPR_FLO_LO]};
  assign phase_shift_enable = active_low_phase[SPR_PHASE_EN_BIT];
  // Phase word reads zero while adjustment is off
  assign phase_word = phase_shift_enable ?
    active_low_phase[SPR_PHASE_HI:SPR_PHASE_LO] : 12'h000;
  assign cycle_slip_reduce_enable = reference_divider_config[SPR_CSR_BIT];
  // Reference settings come from the live copy
  assign pump_current = active_ref_div[SPR_CP_HI:SPR_CP_LO];
  assign ref_half = active_ref_div[SPR_RDIV2_BIT];
  assign ref_double = active_ref_div[SPR_DBL_BIT];
  assign ref_count = active_ref_div[SPR_RCNT_HI:SPR_RCNT_LO];
  assign clk1_divide = active_ref_div[SPR_CLK1_HI:SPR_CLK1_LO];
  // Function bits act at once, power-down included
  assign phase_detector_sense = function_config[SPR_PD_SENSE_BIT];
  assign power_down = function_config[SPR_PWRDN_BIT];

  // Checks
  // All checks sample on clk and stand down while reset is high
  main_store_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> divider_main_word == $past(shifter))
    else $error("main word not stored");
  fractional_divide_word_low_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW |=> fraction_low_phase_word == $past(shifter))
    else $error("fraction low word not stored");
  ref_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_REF_DIV |=> reference_divider_config == $past(shifter))
    else $error("reference word not stored");
  other_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_DELAY |=> ramp_delay_config == $past(shifter))
    else $error("delay word not stored");
  ramp_field_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> ramp_enable == $past(shifter[SPR_RAMP_BIT]))
    else $error("ramp enable wrong");
  int_mux_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> integer_divide == $past(shifter[SPR_INT_HI:SPR_INT_LO])
      && test_signal_output_select == $past(shifter[SPR_MUX_HI:SPR_MUX_LO]))
    else $error("integer or mux field wrong");
  fractional_divide_word_hold_a: assert property (@(posedge clk) disable iff (rst)
    !main_write |=> $stable(active_low_phase) && $stable(active_ref_div))
    else $error("buffered setting moved without main write");
  fractional_divide_word_join_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> fractional_divide_word[12:0] ==
      $past(fraction_low_phase_word[SPR_FLO_HI:SPR_FLO_LO]))
    else $error("fraction low part wrong");
  phase_gate_a: assert property (@(posedge clk) disable iff (rst)
    !phase_shift_enable |-> phase_word == 12'h000 && !$rose(phase_update))
    else $error("phase used while disabled");
  csr_bit_a: assert property (@(posedge clk) disable iff (rst)
    (!(latch_rise && sel == SPR_SEL_REF_DIV) |=> $stable(cycle_slip_reduce_enable)) and
    (latch_rise && sel == SPR_SEL_REF_DIV |=> cycle_slip_reduce_enable ==
      $past(shifter[SPR_CSR_BIT])))
    else $error("slip reduction bit wrong");
  shift_in_a: assert property (@(posedge clk) disable iff (rst)
    sclk_rise |=> shifter[0] == $past(sdat_s) && shifter[31:1] == $past(shifter[30:0]))
    else $error("shift order wrong");
  power_load_a: assert property (@(posedge clk) disable iff (rst)
    power_down && latch_rise && sel == SPR_SEL_CLOCK |=> ramp_clock_config == $past(shifter))
    else $error("load lost in power-down");

  // Each select code touches its own register and no other
  func_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_FUNCTION |=> function_config == $past(shifter))
    else $error("function word not stored");
  clock_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_CLOCK |=> ramp_clock_config == $past(shifter))
    else $error("clock word not stored");
  dev_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_DEVIATION |=> frequency_deviation_config == $past(shifter))
    else $error("deviation word not stored");
  step_store_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_STEP |=> ramp_step_count == $past(shifter))
    else $error("step word not stored");
  main_keep_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel != SPR_SEL_MAIN |=> $stable(divider_main_word))
    else $error("main word hit by other code");
  fractional_divide_word_low_keep_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel != SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW |=> $stable(fraction_low_phase_word))
    else $error("fraction low word hit by other code");
  ref_keep_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel != SPR_SEL_REF_DIV |=> $stable(reference_divider_config))
    else $error("reference word hit by other code");

  // Registers move only on a latch, the shifter only on a shift edge
  latch_only_a: assert property (@(posedge clk) disable iff (rst)
    !latch_rise |=> $stable(divider_main_word) && $stable(fraction_low_phase_word)
      && $stable(reference_divider_config))
    else $error("register moved without strobe");
  raw_hold_a: assert property (@(posedge clk) disable iff (rst)
    !latch_rise |=> $stable(function_config) && $stable(ramp_clock_config)
      && $stable(frequency_deviation_config) && $stable(ramp_step_count)
      && $stable(ramp_delay_config))
    else $error("raw word moved without strobe");
  shift_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sclk_rise |=> $stable(shifter))
    else $error("shifter moved without shift edge");
  latch_pair_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise |=> !latch_rise)
    else $error("one strobe latched twice");

  // Live fraction and phase fields follow the word seen at the main write
  fractional_divide_word_high_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> fractional_divide_word[SPR_FRACTIONAL_DIVIDE_WORD_W-1:SPR_FRACTIONAL_DIVIDE_WORD_SHIFT] ==
      $past(shifter[SPR_FHI_HI:SPR_FHI_LO]))
    else $error("fraction high part wrong");
  main_hold_a: assert property (@(posedge clk) disable iff (rst)
    !main_write |=> $stable(ramp_enable) && $stable(integer_divide))
    else $error("main field moved without main write");
  phase_word_a: assert property (@(posedge clk) disable iff (rst)
    main_write && fraction_low_phase_word[SPR_PHASE_EN_BIT] |=> phase_update &&
      phase_word == $past(fraction_low_phase_word[SPR_PHASE_HI:SPR_PHASE_LO]))
    else $error("phase word not applied at main write");
  phase_off_a: assert property (@(posedge clk) disable iff (rst)
    main_write && !fraction_low_phase_word[SPR_PHASE_EN_BIT] |=> !phase_update)
    else $error("phase pulse with adjustment off");
  pulse_once_a: assert property (@(posedge clk) disable iff (rst)
    phase_update |=> !phase_update)
    else $error("phase pulse longer than one cycle");
  pulse_cause_a: assert property (@(posedge clk) disable iff (rst)
    phase_update |-> phase_shift_enable)
    else $error("phase pulse without enable");

  // Reference settings go live together at the main write
  ref_live_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> pump_current == $past(reference_divider_config[SPR_CP_HI:SPR_CP_LO])
      && ref_count == $past(reference_divider_config[SPR_RCNT_HI:SPR_RCNT_LO])
      && clk1_divide == $past(reference_divider_config[SPR_CLK1_HI:SPR_CLK1_LO]))
    else $error("reference settings not applied");
  ref_bits_a: assert property (@(posedge clk) disable iff (rst)
    main_write |=> ref_half == $past(reference_divider_config[SPR_RDIV2_BIT])
      && ref_double == $past(reference_divider_config[SPR_DBL_BIT]))
    else $error("reference halver or doubler wrong");

  // Power-down is only a stored bit; loading and holding go on regardless
  func_fields_a: assert property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_FUNCTION |=> power_down == $past(shifter[SPR_PWRDN_BIT])
      && phase_detector_sense == $past(shifter[SPR_PD_SENSE_BIT]))
    else $error("function fields wrong");
  power_keep_a: assert property (@(posedge clk) disable iff (rst)
    power_down && !latch_rise |=> $stable(divider_main_word) && $stable(function_config))
    else $error("contents changed in power-down");

  // Scenarios worth seeing at least once
  main_cov_c: cover property (@(posedge clk) disable iff (rst) main_write);
  phase_cov_c: cover property (@(posedge clk) disable iff (rst) phase_update);
  csr_cov_c: cover property (@(posedge clk) disable iff (rst) $rose(cycle_slip_reduce_enable));
  pd_cov_c: cover property (@(posedge clk) disable iff (rst) power_down && latch_rise);
  ref_cov_c: cover property (@(posedge clk) disable iff (rst)
    latch_rise && sel == SPR_SEL_REF_DIV);
endmodule // spr_bank

// ---- verif/spr_host.sv ----
// Host model that loads words over the three-wire serial port
`timescale 1ns/1ns
module spr_host (
  input wire logic clk,
  output logic shift_clk,
  output logic shift_data,
  output logic latch_strobe
);
  // Link pins idle low, shift clock stands still between frames
  initial begin
    shift_clk = 1'b0;
    shift_data = 1'b0;
    latch_strobe = 1'b0;
  end
  // Half of the 400 ns link period, moving just after a system edge
  task automatic half_period();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Thirty-two bits MSB first on rising shift edges, then the strobe
  task automatic send_word(input logic [31:0] word);
    for (int i = 31; i >= 0; i--) begin
      shift_data = word[i];
      half_period();
      shift_clk = 1'b1;
      half_period();
      shift_clk = 1'b0;
    end
    shift_data = ~word[0]; // Released line shows inverse, so a stale bit cannot pass
    half_period();
    latch_strobe = 1'b1;
    half_period();
    latch_strobe = 1'b0;
    half_period();
  endtask
endmodule // spr_host

// ---- verif/spr_bank_tb.sv ----
// Self-checking bench for the program register bank
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module spr_bank_tb
  import spr_pkg::*;
;
  logic clk, rst, shift_clk, shift_data, latch_strobe, ramp_enable, phase_shift_enable;
  logic phase_update, cycle_slip_reduce_enable, ref_half, ref_double;
  logic phase_detector_sense, power_down;
  logic [3:0] test_signal_output_select, pump_current;
  logic [11:0] integer_divide, phase_word, clk1_divide;
  logic [24:0] fractional_divide_word;
  logic [4:0] ref_count;
  logic [31:0] function_config, ramp_clock_config, frequency_deviation_config;
  logic [31:0] ramp_step_count, ramp_delay_config;
  int fails, n_checks, pulses;
  spr_host host_u (.clk, .shift_clk, .shift_data, .latch_strobe);
  spr_bank dut_u (.clk, .rst, .shift_clk, .shift_data, .latch_strobe, .ramp_enable,
    .test_signal_output_select, .integer_divide, .fractional_divide_word,
    .phase_shift_enable, .phase_word, .phase_update, .cycle_slip_reduce_enable,
    .pump_current, .ref_half, .ref_double, .ref_count, .clk1_divide,
    .phase_detector_sense, .power_down, .function_config, .ramp_clock_config,
    .frequency_deviation_config, .ramp_step_count, .ramp_delay_config);
  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Count one-cycle phase pulses so a doubled pulse is caught too
  always @(posedge clk) begin
    if (phase_update === 1'b1) pulses <= pulses + 1;
  end
  task automatic send(input logic [31:0] w);
    host_u.send_word(w);
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    `CHK(ramp_enable, 1'b0)
    `CHK(fractional_divide_word, 25'h0)
    `CHK(function_config, 32'h0)
    `CHK(integer_divide, 12'h0)
    `CHK(ref_count, 5'h0)
    `CHK(cycle_slip_reduce_enable, 1'b0)
    `CHK(ramp_clock_config, 32'h0)
  endtask
  // Function word first with power-down set, then the rest load regardless
  task automatic t_raw();
    logic [31:0] w [5];
    w = '{32'h0002_0063, 32'h8765_4304, 32'h2A5F_0F05, 32'h00C3_5A5E, 32'h0065_A1B7};
    foreach (w[i]) send(w[i]);
    `CHK(function_config, w[0])
    `CHK(phase_detector_sense, 1'b1)
    `CHK(power_down, 1'b1)
    `CHK(ramp_clock_config, w[1])
    `CHK(frequency_deviation_config, w[2])
    `CHK(ramp_step_count, w[3])
    `CHK(ramp_delay_config, w[4])
  endtask
  // Second and third registers wait for the main write; slip bit does not
  task automatic t_buffered();
    send({3'h0, 1'b1, 13'h1ABC, 12'h200, SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW});
    `CHK(fractional_divide_word, 25'h0)
    `CHK(phase_shift_enable, 1'b0)
    send({3'h0, 1'b0, 4'h5, 4'h2, 5'h13, 12'hABC, SPR_SEL_REF_DIV});
    `CHK(pump_current, 4'h0)
    `CHK(ref_count, 5'h0)
    `CHK(cycle_slip_reduce_enable, 1'b0)
    pulses = 0;
    send({1'b1, 4'hA, 12'h123, 12'hFED, SPR_SEL_MAIN});
    `CHK(ramp_enable, 1'b1)
    `CHK(test_signal_output_select, 4'hA)
    `CHK(integer_divide, 12'h123)
    `CHK(fractional_divide_word, {12'hFED, 13'h1ABC})
    `CHK(phase_shift_enable, 1'b1)
    `CHK(phase_word, 12'h200)
    `CHK(pulses, 1)
    `CHK({pump_current, ref_half, ref_double}, 6'h16)
    `CHK({ref_count, clk1_divide}, {5'h13, 12'hABC})
    // Slip reduction only with minimum pump code and positive sense; the bank does not gate it, so slip turns on at once with live pump still 5
    send({3'h0, 1'b1, 4'h0, 4'h2, 5'h13, 12'hABC, SPR_SEL_REF_DIV});
    `CHK(cycle_slip_reduce_enable, 1'b1)
    `CHK(pump_current, 4'h5)
  endtask
  // Phase adjustment off with a zero phase word; no pulse may appear
  task automatic t_phase_off();
    send({3'h0, 1'b0, 13'h0001, 12'h000, SPR_SEL_FRACTIONAL_DIVIDE_WORD_LOW});
    pulses = 0;
    send({1'b0, 4'h3, 12'h0FF, 12'h001, SPR_SEL_MAIN});
    `CHK(ramp_enable, 1'b0)
    `CHK(phase_shift_enable, 1'b0)
    `CHK(phase_word, 12'h000)
    `CHK(pulses, 0)
    `CHK(fractional_divide_word, {12'h001, 13'h0001})
    `CHK(pump_current, 4'h0)
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Traffic takes about 0.15 ms; 1 ms means something hung
  initial begin
    #1000000;
    fails++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    fails = 0;
    n_checks = 0;
    pulses = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_raw();
    t_buffered();
    t_phase_off();
    // Reset again in mid-run; every setting must fall back to zero
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    summarize();
  end
endmodule // spr_bank_tb
